// ===== hdl/ldo_regulator_control.sv
/*
 * Control logic for six linear regulators: control registers, voltage
 * target decode, output state, pull-down, low-power and short protection.
 * Assumes a host writes control bits through plain ports, synchronous to clk.
 */
`timescale 1ns/100ps
module ldo_regulator_control
	import ldo_pkg::*;
#(
	parameter int N            = ldo_pkg::LDO_COUNT,
	parameter int DEBOUNCE_CYC = ldo_pkg::LDO_DEBOUNCE_CYC
) (
	// Clock and reset.
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	// Control register writes, one strobe per regulator.
	input  wire logic [N-1:0]                  ldo_ctl_wr,
	input  wire logic [7:0]                    ldo_ctl_wdata,
	output logic [N-1:0][7:0]                  ldo_control_register,
	// Global protection mode.
	input  wire logic                          short_shutdown_wr,
	input  wire logic                          short_shutdown_wdata,
	output logic                               short_shutdown_enable,
	// Fault flags, masks and interrupt.
	input  wire logic [N-1:0]                  ldo_fault_irq_mask,
	input  wire logic [N-1:0]                  ldo_fault_clear,
	output logic [N-1:0]                       ldo_fault_irq_flag,
	output logic                               ldo_fault_irq,
	// System state and analog sense.
	input  wire logic                          processor_reset_out_n,
	input  wire logic                          standby_event,
	input  wire logic [N-1:0]                  ldo_raw_short,
	input  wire logic [N-1:0]                  ldo_light_load,
	// Analog controls.
	output ldo_pkg::ldo_out_state_t [N-1:0]    ldo_out_state,
	output logic [N-1:0]                       ldo_pull_down,
	output logic [N-1:0]                       ldo_reduced_bias,
	output logic [N-1:0]                       ldo_lowest_bias,
	output logic [N-1:0][ldo_pkg::LDO_MV_W-1:0] ldo_target_mv
);
	////////////////////////////////////////////////////////////////////////
	function automatic logic [LDO_MV_W-1:0] target_mv(input int idx,
		input logic [LDO_CODE_W-1:0] code);
		logic [LDO_MV_W-1:0] c;
		c = LDO_MV_W'(code);
		if (idx < LDO_LOW_GROUP)
			return LDO_MV_W'(LDO_LOW_BASE_MV + c * LDO_LOW_STEP_MV);
		return LDO_MV_W'(LDO_HIGH_BASE_MV + c * LDO_HIGH_STEP_MV);
	endfunction : target_mv

	function automatic ldo_out_state_t out_state(input logic [7:0] ctl,
		input logic stby);
		if (!ctl[LDO_CTL_EN]) return LDO_OUT_OFF;
		if (ctl[LDO_CTL_STBY] && !stby) return LDO_OUT_ON;
		if (ctl[LDO_CTL_LPWR]) return LDO_OUT_LOW_POWER;
		return ctl[LDO_CTL_STBY] ? LDO_OUT_OFF : LDO_OUT_ON;
	endfunction : out_state

	////////////////////////////////////////////////////////////////////////
	logic [N-1:0] short_det;

	for (genvar g = 0; g < N; g++) begin : g_db
		ldo_short_debounce #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_db (
			.clk          (clk),
			.rst_n        (rst_n),
			.raw_short    (ldo_raw_short[g]),
			.short_detect (short_det[g])
		);
	end

	////////////////////////////////////////////////////////////////////////
	logic [N-1:0][7:0] ctl_q, ctl_d;
	logic              scp_q, scp_d;
	logic [N-1:0]      flag_q, flag_d;

	// Hardware shutdown beats a same-cycle software write; flag set beats clear.
	always_comb begin
		ctl_d  = ctl_q;
		scp_d  = scp_q;
		flag_d = flag_q;
		if (short_shutdown_wr)
			scp_d = short_shutdown_wdata;
		for (int i = 0; i < N; i++) begin
			if (ldo_ctl_wr[i])
				ctl_d[i] = ldo_ctl_wdata & LDO_CTL_WMASK;
			if (ldo_fault_clear[i])
				flag_d[i] = 1'b0;
			if (short_det[i]) begin
				flag_d[i] = 1'b1;
				if (scp_q)
					ctl_d[i][LDO_CTL_EN] = 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctl_q  <= {N{LDO_CTL_RESET}};
			scp_q  <= SHORT_SHUTDOWN_RESET;
			flag_q <= '0;
		end else begin
			ctl_q  <= ctl_d;
			scp_q  <= scp_d;
			flag_q <= flag_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	ldo_out_state_t [N-1:0]              st_q, st_d;
	logic [N-1:0]                        pd_q, pd_d, rb_q, rb_d, lb_q, lb_d;
	logic [N-1:0][LDO_MV_W-1:0]          mv_q, mv_d;
	logic                                irq_q, irq_d;

	// Outputs are registered, so each follows the control bits one cycle later.
	always_comb begin
		irq_d = |(flag_q & ~ldo_fault_irq_mask);
		for (int i = 0; i < N; i++) begin
			st_d[i] = out_state(ctl_q[i], standby_event);
			pd_d[i] = !ctl_q[i][LDO_CTL_EN] || !processor_reset_out_n;
			lb_d[i] = (st_d[i] == LDO_OUT_LOW_POWER);
			rb_d[i] = lb_d[i] || (st_d[i] == LDO_OUT_ON && ldo_light_load[i]);
			mv_d[i] = target_mv(i, ctl_q[i][LDO_CODE_W-1:0]);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			// Outputs come up off with every pull-down engaged.
			for (int i = 0; i < N; i++)
				st_q[i] <= LDO_OUT_OFF;
			pd_q  <= '1;
			rb_q  <= '0;
			lb_q  <= '0;
			mv_q  <= '0;
			irq_q <= 1'b0;
		end else begin
			st_q  <= st_d;
			pd_q  <= pd_d;
			rb_q  <= rb_d;
			lb_q  <= lb_d;
			mv_q  <= mv_d;
			irq_q <= irq_d;
		end
	end

	assign ldo_control_register  = ctl_q;
	assign short_shutdown_enable = scp_q;
	assign ldo_fault_irq_flag    = flag_q;
	assign ldo_fault_irq         = irq_q;
	assign ldo_out_state         = st_q;
	assign ldo_pull_down         = pd_q;
	assign ldo_reduced_bias      = rb_q;
	assign ldo_lowest_bias       = lb_q;
	assign ldo_target_mv         = mv_q;

	////////////////////////////////////////////////////////////////////////
	a_mask_blocks_irq: assert property (@(posedge clk) disable iff (!rst_n)
		(flag_q == '0 || (flag_q & ~ldo_fault_irq_mask) == '0) |=> !ldo_fault_irq)
		else $error("Masked fault raised the interrupt.");
	a_irq_unmasked: assert property (@(posedge clk) disable iff (!rst_n)
		(flag_q & ~ldo_fault_irq_mask) != '0 |=> ldo_fault_irq)
		else $error("Unmasked fault did not raise the interrupt.");
	a_pull_down_rst: assert property (@(posedge clk) disable iff (!rst_n)
		!processor_reset_out_n |=> ldo_pull_down == '1)
		else $error("Pull-down off while processor reset low.");

	// Every channel is watched, so a fault on any regulator is covered.
	for (genvar g = 0; g < N; g++) begin : g_chk
		a_shutdown_clears_en: assert property (@(posedge clk) disable iff (!rst_n)
			(short_det[g] && scp_q) |=> !ctl_q[g][LDO_CTL_EN] && flag_q[g])
			else $error("Shutdown did not clear enable and set flag.");
		a_limit_keeps_en: assert property (@(posedge clk) disable iff (!rst_n)
			(short_det[g] && !scp_q && !ldo_ctl_wr[g]) |=> $stable(ctl_q[g]))
			else $error("Limiting mode changed the control register.");
		a_flag_any_mode: assert property (@(posedge clk) disable iff (!rst_n)
			short_det[g] |=> flag_q[g])
			else $error("Fault flag not raised.");
		a_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n)
			(flag_q[g] && !ldo_fault_clear[g]) |=> flag_q[g])
			else $error("Fault flag dropped without a clear.");
		a_pull_down_dis: assert property (@(posedge clk) disable iff (!rst_n)
			!ctl_q[g][LDO_CTL_EN]
			|=> ldo_pull_down[g] && ldo_out_state[g] == LDO_OUT_OFF)
			else $error("Disabled regulator lacks pull-down.");
		a_force_lowest: assert property (@(posedge clk) disable iff (!rst_n)
			(ctl_q[g][LDO_CTL_EN] && ctl_q[g][LDO_CTL_LPWR] && !ctl_q[g][LDO_CTL_STBY])
			|=> ldo_lowest_bias[g] && ldo_reduced_bias[g])
			else $error("Forced low power not applied.");
		a_reduced_light: assert property (@(posedge clk) disable iff (!rst_n)
			(ctl_q[g][LDO_CTL_EN] && ctl_q[g][6:5] == 2'h0 && ldo_light_load[g])
			|=> ldo_reduced_bias[g] && !ldo_lowest_bias[g])
			else $error("Light load did not reduce bias.");
		if (g < LDO_LOW_GROUP) begin : g_low
			a_target_low: assert property (@(posedge clk) disable iff (!rst_n)
				1'b1 |=> ldo_target_mv[g] == LDO_LOW_BASE_MV
				+ LDO_LOW_STEP_MV * LDO_MV_W'($past(ctl_q[g][LDO_CODE_W-1:0])))
				else $error("Low group voltage target wrong.");
		end else begin : g_high
			a_target_high: assert property (@(posedge clk) disable iff (!rst_n)
				1'b1 |=> ldo_target_mv[g] == LDO_HIGH_BASE_MV
				+ LDO_HIGH_STEP_MV * LDO_MV_W'($past(ctl_q[g][LDO_CODE_W-1:0])))
				else $error("High group voltage target wrong.");
		end
	end
endmodule : ldo_regulator_control

// ===== hdl/ldo_pkg.sv
/*
 * Package for the LDO regulator control block: control register layout,
 * reset values, voltage code scaling, debounce length and output states.
 * Assumes nothing of its surroundings.
 */
package ldo_pkg;
	localparam int LDO_COUNT       = 6;
	localparam int LDO_CODE_W      = 4;
	localparam int LDO_MV_W        = 12;
	localparam int LDO_CTL_CODE_LO = 0;
	localparam int LDO_CTL_EN      = 4;
	localparam int LDO_CTL_STBY    = 5;
	localparam int LDO_CTL_LPWR    = 6;
	localparam logic [7:0] LDO_CTL_RESET = 8'h80;
	localparam logic [7:0] LDO_CTL_WMASK = 8'h7f;
	localparam logic       SHORT_SHUTDOWN_RESET = 1'b0;
	localparam int LDO_LOW_GROUP   = 2;
	localparam logic [LDO_MV_W-1:0] LDO_LOW_BASE_MV  = 12'h320;
	localparam logic [LDO_MV_W-1:0] LDO_LOW_STEP_MV  = 12'h032;
	localparam logic [LDO_MV_W-1:0] LDO_HIGH_BASE_MV = 12'h708;
	localparam logic [LDO_MV_W-1:0] LDO_HIGH_STEP_MV = 12'h064;
	localparam int LDO_AUTO_LP_DIV  = 5;
	localparam int LDO_FORCE_LP_DIV = 50;
	localparam int LDO_DEBOUNCE_NS   = 1000;
	localparam int LDO_CLK_PERIOD_NS = 10;
	localparam int LDO_DEBOUNCE_CYC  = (LDO_DEBOUNCE_NS + LDO_CLK_PERIOD_NS - 1)
		/ LDO_CLK_PERIOD_NS;
	localparam int LDO_DB_W          = 8;

	typedef enum logic [1:0] {
		LDO_OUT_OFF,
		LDO_OUT_ON,
		LDO_OUT_LOW_POWER
	} ldo_out_state_t;
endpackage : ldo_pkg

// ===== hdl/ldo_short_debounce.sv
/*
 * Short-circuit debounce for one regulator: a fault is reported as a
 * one-cycle pulse once the raw comparator level has persisted for
 * DEBOUNCE_CYC cycles. Assumes the raw level is synchronous to clk.
 */
`timescale 1ns/100ps
module ldo_short_debounce
	import ldo_pkg::*;
#(
	parameter int DEBOUNCE_CYC = ldo_pkg::LDO_DEBOUNCE_CYC
) (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic rst_n,
	// Raw detector level and debounced detection.
	input  wire logic raw_short,
	output logic      short_detect
);
	logic [LDO_DB_W-1:0] cnt_q, cnt_d;
	logic                det_q, det_d;

	// Counts consecutive cycles of fault; the pulse fires once per episode.
	always_comb begin
		cnt_d = cnt_q;
		det_d = 1'b0;
		if (!raw_short) begin
			cnt_d = '0;
		end else if (cnt_q < LDO_DB_W'(DEBOUNCE_CYC)) begin
			cnt_d = cnt_q + LDO_DB_W'(1);
			det_d = (cnt_q == LDO_DB_W'(DEBOUNCE_CYC - 1));
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_q <= '0;
			det_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			det_q <= det_d;
		end
	end

	assign short_detect = det_q;

	a_debounce_len: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(det_q) |-> $past(raw_short, 1) && $past(raw_short, 2))
		else $error("Short reported without a persisting fault.");
endmodule : ldo_short_debounce

// ===== sim/ldo_host_model.sv
/*
 * Host software model: drives control register writes, the protection
 * bit, fault masks and fault clears. Assumes the bench clock.
 */
`timescale 1ns/100ps
module ldo_host_model
	import ldo_pkg::*;
(
	// Clock.
	input  wire logic                        clk,
	// Register side of the block.
	output logic [ldo_pkg::LDO_COUNT-1:0]   ldo_ctl_wr,
	output logic [7:0]                      ldo_ctl_wdata,
	output logic                            short_shutdown_wr,
	output logic                            short_shutdown_wdata,
	output logic [ldo_pkg::LDO_COUNT-1:0]   ldo_fault_irq_mask,
	output logic [ldo_pkg::LDO_COUNT-1:0]   ldo_fault_clear
);
	initial begin
		ldo_ctl_wr = '0;
		ldo_ctl_wdata = 8'h00;
		short_shutdown_wr = 1'b0;
		short_shutdown_wdata = 1'b0;
		ldo_fault_irq_mask = '0;
		ldo_fault_clear = '0;
	end

	////////////////////////////////////////////////////////////////////////
	// Forced low power is written by the bench with light load on channel 2 and without it on channel 3.
	// Every strobe lasts one cycle; released data is inverted.
	task automatic wr_ctl(input int i, input logic [7:0] d);
		@(negedge clk);
		ldo_ctl_wdata = d;
		ldo_ctl_wr[i] = 1'b1;
		@(negedge clk);
		ldo_ctl_wr = '0;
		ldo_ctl_wdata = ~d;
	endtask : wr_ctl

	task automatic wr_prot(input logic v);
		@(negedge clk);
		short_shutdown_wdata = v;
		short_shutdown_wr = 1'b1;
		@(negedge clk);
		short_shutdown_wr = 1'b0;
		short_shutdown_wdata = ~v;
	endtask : wr_prot

	task automatic clr(input int i);
		@(negedge clk);
		ldo_fault_clear[i] = 1'b1;
		@(negedge clk);
		ldo_fault_clear = '0;
	endtask : clr
endmodule : ldo_host_model

// ===== sim/tb_top.sv
/*
 * Self-checking bench for the regulator control block.
 * Assumes the host model drives all register-side inputs.
 */
`timescale 1ns/100ps
module tb_top;
	import ldo_pkg::*;
	logic                  clk = 1'b0;
	logic                  rst_n = 1'b0;
	logic                  pr_n = 1'b1;
	logic                  sby = 1'b0;
	logic [5:0]            raw = '0;
	logic [5:0]            light = '0;
	logic [5:0]            wr, mask, clr, flag, pd, rb, lb;
	logic [5:0][7:0]       ctl;
	logic [7:0]            wd;
	logic                  p_wr, p_d, prot, irq;
	ldo_out_state_t [5:0]  st;
	logic [5:0][11:0]      mv;
	int                    error_cnt = 0;
	int                    n_compared = 0;

	always #5 clk = ~clk;

	ldo_host_model host (.clk(clk), .ldo_ctl_wr(wr), .ldo_ctl_wdata(wd),
		.short_shutdown_wr(p_wr), .short_shutdown_wdata(p_d),
		.ldo_fault_irq_mask(mask), .ldo_fault_clear(clr));
	ldo_regulator_control #(.N(6), .DEBOUNCE_CYC(3)) dut (.clk(clk), .rst_n(rst_n),
		.ldo_ctl_wr(wr), .ldo_ctl_wdata(wd), .ldo_control_register(ctl),
		.short_shutdown_wr(p_wr), .short_shutdown_wdata(p_d),
		.short_shutdown_enable(prot), .ldo_fault_irq_mask(mask),
		.ldo_fault_clear(clr), .ldo_fault_irq_flag(flag), .ldo_fault_irq(irq),
		.processor_reset_out_n(pr_n), .standby_event(sby), .ldo_raw_short(raw),
		.ldo_light_load(light), .ldo_out_state(st), .ldo_pull_down(pd),
		.ldo_reduced_bias(rb), .ldo_lowest_bias(lb), .ldo_target_mv(mv));

	task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : check

	task automatic settle();
		repeat (3) @(negedge clk);
	endtask : settle

	task automatic close_out();
		$display("Compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : close_out

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		for (int i = 0; i < 6; i++)
			check("ctl_rst", {8'h00, ctl[i]}, {8'h00, LDO_CTL_RESET});
		check("prot_rst", {15'h0, prot}, 16'h0000);
		check("pd_rst", {10'h0, pd}, 16'h003f);
	endtask : t_reset

	task automatic t_decode();
		for (int i = 0; i < 6; i++) begin
			for (int c = 0; c < 16; c++) begin
				host.wr_ctl(i, 8'h90 | 8'(c));
				settle();
				check("ctl", {8'h00, ctl[i]}, 16'h0010 | 16'(c));
				check("mv", {4'h0, mv[i]}, (i < 2) ? 16'(800 + 50 * c)
					: 16'(1800 + 100 * c));
				check("pd_on", {15'h0, pd[i]}, 16'h0000);
			end
			host.wr_ctl(i, 8'h00);
			settle();
			check("pd_off", {15'h0, pd[i]}, 16'h0001);
		end
	endtask : t_decode

	task automatic t_state();
		ldo_out_state_t e;
		for (int k = 0; k < 16; k++) begin
			sby = k[3];
			host.wr_ctl(3, {1'b0, k[2], k[1], k[0], 4'h0});
			settle();
			if (!k[0]) e = LDO_OUT_OFF;
			else if (k[1] && k[3] && !k[2]) e = LDO_OUT_OFF;
			else if (k[2] && (!k[1] || k[3])) e = LDO_OUT_LOW_POWER;
			else e = LDO_OUT_ON;
			check("state", 16'(st[3]), 16'(e));
		end
		sby = 1'b0;
	endtask : t_state

	task automatic t_bias();
		host.wr_ctl(2, 8'h10);
		light[2] = 1'b1;
		settle();
		check("rbias", {15'h0, rb[2]}, 16'h0001);
		host.wr_ctl(2, 8'h50);
		settle();
		check("lbias", {15'h0, lb[2]}, 16'h0001);
		light[2] = 1'b0;
		host.wr_ctl(2, 8'h10);
		settle();
		check("rbias0", {14'h0, rb[2], lb[2]}, 16'h0000);
	endtask : t_bias

	task automatic t_preset();
		host.wr_ctl(1, 8'h10);
		pr_n = 1'b0;
		settle();
		check("pd_prst", {10'h0, pd}, 16'h003f);
		pr_n = 1'b1;
		settle();
		check("pd_rel", {15'h0, pd[1]}, 16'h0000);
	endtask : t_preset

	task automatic t_short(input logic p);
		int n;
		host.wr_prot(p);
		check("prot", {15'h0, prot}, {15'h0, p});
		host.wr_ctl(4, 8'h10);
		raw[4] = 1'b1;
		repeat (2) @(negedge clk);
		raw[4] = 1'b0;
		settle();
		check("glitch", {15'h0, flag[4]}, 16'h0000);
		raw[4] = 1'b1;
		n = 0;
		while (flag[4] !== 1'b1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		if (flag[4] !== 1'b1) begin
			error_cnt++;
			close_out();
		end
		raw[4] = 1'b0;
		check("flag", {15'h0, flag[4]}, 16'h0001);
		check("en", {15'h0, ctl[4][4]}, {15'h0, ~p});
		settle();
		check("irq", {15'h0, irq}, 16'h0001);
		check("st_sc", 16'(st[4]), p ? 16'(LDO_OUT_OFF) : 16'(LDO_OUT_ON));
		host.ldo_fault_irq_mask[4] = 1'b1;
		settle();
		check("irq_m", {14'h0, irq, flag[4]}, 16'h0001);
		host.ldo_fault_irq_mask[4] = 1'b0;
		host.clr(4);
		settle();
		check("flag_c", {14'h0, irq, flag[4]}, 16'h0000);
	endtask : t_short

	initial begin
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		t_reset();
		t_decode();
		t_state();
		t_bias();
		t_preset();
		t_short(1'b0);
		t_short(1'b1);
		close_out();
	end

	initial begin
		#900000;
		error_cnt++;
		close_out();
	end
endmodule : tb_top
